// *** rtl/evgt_even_gray_table.sv ***
/*
 Even gray-level timing table bank with sleep select and software reinit,
 reached over an AHB-Lite slave, plus the gray-step clock and level sweep.
 Assumes one 20 MHz clock, a single AHB-Lite master and word transfers only.
*/
// The implementer's own choice: the AHB-Lite slave port.
// Functional notes
// - Each level lasts its byte plus one gray-step periods; level 13 defaults 79h.
// - Code 31h loads level 12; default 53h.
// - Level 11 has its own load command; default 39h.
// - Code 33h loads level 10; default 27h.
// - Code 34h loads level 9; default 1Ah.
// - Code 35h loads level 8; default 12h.
// - Code 36h loads level 7; default 0Ch.
// - Code 37h loads level 6; default 08h.
// - Code 38h loads level 5; default 05h.
// - Level 4 has its own load command; default 03h.
// - Code 3Ah loads level 3; default 02h.
// - Code 3Bh loads level 2; default 01h.
// - Code 3Ch loads level 1; default 00h.
// - Code F1h data bit 0 selects sleep; other bits ignored; default 00h.
// - Code F2h with any data reinitialises within 200 ns.
// - After reinit oscillator runs, step-up off, column and row drivers low.
// - After reinit driver clock follows gray clock; sync and row outputs low.
// - Reinit returns every table entry and sleep select to defaults.
`timescale 1ns/1ps
`default_nettype none

module evgt_even_gray_table #(
   parameter int unsigned GSTEP_HALF_DIV = evgt_pkg::GSTEP_HALF_DIV_DEF
) (
   // System
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Driver control
   output logic             SCLK_OUT,
   output logic             FRAME_SYNC_OUT,
   output logic             ROW_SYNC_OUT,
   output logic             ROW_CTRL_A_OUT,
   output logic             ROW_CTRL_B_OUT,
   output logic             ROW_SHIFT_BIT_OUT,
   // Power and status
   output logic             OSC_RUN_OUT,
   output logic             STEPUP_EN_OUT,
   output logic             COL_DRV_LOW_OUT,
   output logic             ROW_DRV_LOW_OUT,
   output logic             SLEEP_OUT,
   output logic      [3:0]  GRAY_LEVEL_OUT
);

   localparam int unsigned NL  = evgt_pkg::NUM_LEVELS;
   localparam int unsigned DW  = evgt_pkg::DATA_W;
   localparam int unsigned IW  = evgt_pkg::IDX_W;
   localparam int unsigned LW  = evgt_pkg::LVL_W;
   localparam int unsigned DVW = $clog2(GSTEP_HALF_DIV + 1);
   localparam int unsigned RCW = $clog2(evgt_pkg::SOFT_REINIT_CYC + 1);
   localparam logic [LW-1:0] LVL_FIRST = LW'(1);
   localparam logic [LW-1:0] LVL_LAST  = LW'(NL);

   // Bus phase state
   logic          wr_pend_q;
   logic [IW-1:0] wr_idx_q;
   logic [31:0]   hrdata_q;

   // Command path
   logic          cmd_valid;
   logic [DW-1:0] cmd_code;
   logic [DW-1:0] cmd_data;
   logic          cmd_take;
   logic          reinit;
   logic [LW-1:0] cmd_lvl;

   // Register state
   logic [DW-1:0] tbl_q [NL];
   logic          sleep_q;
   logic          run_q;
   logic          stepup_q;
   logic [DW-1:0] last_code_q;
   logic [RCW-1:0] reinit_cnt_q;
   logic          busy;

   // Gray clock and sweep
   logic [DVW-1:0] div_cnt_q;
   logic          half_tick;
   logic          gclk_q;
   logic          gstep_tick;
   logic          active;
   logic [LW-1:0] level_q;
   logic          slot_done;
   logic          frame_end;

   // Output flops
   logic          frame_sync_q;
   logic          row_sync_q;
   logic          ctrl_a_q;
   logic          ctrl_b_q;
   logic          shift_bit_q;
   logic          osc_q;
   logic          stepup_out_q;
   logic          col_low_q;
   logic          row_low_q;
   logic [LW-1:0] gray_out_q;

   // Address phase capture; only whole-word writes are taken
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= '0;
      end else begin
         wr_pend_q <= HSEL & HTRANS[1] & HREADY & HWRITE & (HSIZE == evgt_pkg::HSIZE_WORD);
         wr_idx_q  <= HADDR[IW+1:2];
      end
   end

   // Command source: the command word register or a direct table, sleep or reinit word
   always_comb begin
      cmd_valid = 1'b0;
      cmd_code  = '0;
      cmd_data  = HWDATA[evgt_pkg::CMD_DATA_LSB +: DW];
      if (wr_pend_q) begin
         if (wr_idx_q == evgt_pkg::IDX_CMD_WORD) begin
            cmd_valid = 1'b1;
            cmd_code  = HWDATA[evgt_pkg::CMD_CODE_LSB +: DW];
         end else if (evgt_pkg::cmd_level(wr_idx_q) != '0 ||
                      wr_idx_q == evgt_pkg::CODE_SLEEP ||
                      wr_idx_q == evgt_pkg::CODE_SOFT_REINIT) begin
            cmd_valid = 1'b1;
            cmd_code  = wr_idx_q;
         end
      end
   end

   // Commands are dropped while a reinit is still settling
   assign busy     = (reinit_cnt_q != '0);
   assign cmd_take = cmd_valid & ~busy;
   assign reinit   = cmd_take & (cmd_code == evgt_pkg::CODE_SOFT_REINIT);
   assign cmd_lvl  = evgt_pkg::cmd_level(cmd_code);

   // Reinit busy window, data byte is ignored
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         reinit_cnt_q <= '0;
      end else if (reinit) begin
         reinit_cnt_q <= RCW'(evgt_pkg::SOFT_REINIT_CYC);
      end else if (busy) begin
         reinit_cnt_q <= RCW'(reinit_cnt_q - 1'b1);
      end
   end

   // Timing table; reinit restores every default
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < NL; i++) begin
            tbl_q[i] <= evgt_pkg::lvl_default(LW'(i + 1));
         end
      end else if (reinit) begin
         for (int i = 0; i < NL; i++) begin
            tbl_q[i] <= evgt_pkg::lvl_default(LW'(i + 1));
         end
      end else if (cmd_take && cmd_lvl != '0) begin
         tbl_q[LW'(cmd_lvl - 1'b1)] <= cmd_data;
      end
   end

   // Sleep select, only bit 0 of the data byte counts
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sleep_q <= evgt_pkg::RST_SLEEP[evgt_pkg::SLEEP_SEL_BIT];
      end else if (reinit) begin
         sleep_q <= evgt_pkg::RST_SLEEP[evgt_pkg::SLEEP_SEL_BIT];
      end else if (cmd_take && cmd_code == evgt_pkg::CODE_SLEEP) begin
         sleep_q <= cmd_data[evgt_pkg::SLEEP_SEL_BIT];
      end
   end

   // Control register: sweep run and step-up enable
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_q    <= 1'b0;
         stepup_q <= 1'b0;
      end else if (reinit) begin
         run_q    <= 1'b0;
         stepup_q <= 1'b0;
      end else if (wr_pend_q && wr_idx_q == evgt_pkg::IDX_CTRL && !busy) begin
         run_q    <= HWDATA[evgt_pkg::CTRL_RUN_BIT];
         stepup_q <= HWDATA[evgt_pkg::CTRL_STEPUP_BIT];
      end
   end

   // Last accepted command code, for status
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         last_code_q <= '0;
      end else if (cmd_take) begin
         last_code_q <= cmd_code;
      end
   end

   // Read data registered in the address phase; table words are write-only
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hrdata_q <= '0;
      end else if (HSEL && HTRANS[1] && HREADY && !HWRITE) begin
         hrdata_q <= '0;
         case (HADDR[IW+1:2])
            evgt_pkg::IDX_CTRL: begin
               hrdata_q[evgt_pkg::CTRL_RUN_BIT]    <= run_q;
               hrdata_q[evgt_pkg::CTRL_STEPUP_BIT] <= stepup_q;
            end
            evgt_pkg::IDX_STATUS: begin
               hrdata_q[evgt_pkg::ST_SLEEP_BIT]          <= sleep_q;
               hrdata_q[evgt_pkg::ST_BUSY_BIT]           <= busy;
               hrdata_q[evgt_pkg::ST_RUN_BIT]            <= active;
               hrdata_q[evgt_pkg::ST_STEPUP_BIT]         <= stepup_out_q;
               hrdata_q[evgt_pkg::ST_LEVEL_LSB +: LW]    <= gray_out_q;
               hrdata_q[evgt_pkg::ST_CODE_LSB +: DW]     <= last_code_q;
            end
            default: begin
               hrdata_q <= '0;
            end
         endcase
      end
   end

   // Zero-wait slave, always OKAY
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   assign HRDATA = hrdata_q;

   // Gray-step clock divider; keeps running through reinit and sleep
   assign half_tick = (div_cnt_q == DVW'(GSTEP_HALF_DIV - 1));

   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_cnt_q <= '0;
         gclk_q    <= 1'b0;
      end else begin
         div_cnt_q <= half_tick ? '0 : DVW'(div_cnt_q + 1'b1);
         if (half_tick) begin
            gclk_q <= ~gclk_q;
         end
      end
   end

   // One step per gray clock period, on its rising half
   assign gstep_tick = half_tick & ~gclk_q;
   assign active     = run_q & ~sleep_q & ~busy;
   assign frame_end  = slot_done & (level_q == LVL_LAST);

   // Slot length comes from the entry of the current level
   evgt_slot_timer #(
      .W (DW)
   ) u_slot (
      .clk     (CLK),
      .rst_n   (RESET_N),
      .restart (~active),
      .tick    (gstep_tick & active),
      .len     (tbl_q[LW'(level_q - 1'b1)]),
      .done    (slot_done)
   );

   // Level sweep 1 up to 13, restarts at level 1 when idle
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         level_q <= LVL_FIRST;
      end else if (!active) begin
         level_q <= LVL_FIRST;
      end else if (slot_done) begin
         level_q <= frame_end ? LVL_FIRST : LW'(level_q + 1'b1);
      end
   end

   // Driver strobes; held low while idle so reinit leaves them low
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         frame_sync_q <= 1'b0;
         row_sync_q   <= 1'b0;
         ctrl_a_q     <= 1'b0;
         ctrl_b_q     <= 1'b0;
         shift_bit_q  <= 1'b0;
      end else begin
         frame_sync_q <= active & frame_end;
         row_sync_q   <= active & slot_done;
         ctrl_a_q     <= active;
         ctrl_b_q     <= active & (level_q == LVL_FIRST);
         shift_bit_q  <= active & frame_end;
      end
   end

   // Supplies and driver rails; step-up stays off in sleep and reinit
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         osc_q        <= 1'b1;
         stepup_out_q <= 1'b0;
         col_low_q    <= 1'b1;
         row_low_q    <= 1'b1;
         gray_out_q   <= '0;
      end else begin
         osc_q        <= 1'b1;
         stepup_out_q <= stepup_q & ~sleep_q & ~busy;
         col_low_q    <= ~active;
         row_low_q    <= ~active;
         gray_out_q   <= active ? level_q : '0;
      end
   end

   assign SCLK_OUT          = gclk_q;
   assign FRAME_SYNC_OUT    = frame_sync_q;
   assign ROW_SYNC_OUT      = row_sync_q;
   assign ROW_CTRL_A_OUT    = ctrl_a_q;
   assign ROW_CTRL_B_OUT    = ctrl_b_q;
   assign ROW_SHIFT_BIT_OUT = shift_bit_q;
   assign OSC_RUN_OUT       = osc_q;
   assign STEPUP_EN_OUT     = stepup_out_q;
   assign COL_DRV_LOW_OUT   = col_low_q;
   assign ROW_DRV_LOW_OUT   = row_low_q;
   assign SLEEP_OUT         = sleep_q;
   assign GRAY_LEVEL_OUT    = gray_out_q;

endmodule

`default_nettype wire

// *** rtl/evgt_pkg.sv ***
/*
 Constants, register map and default table for the even gray-level timing bank.
 Assumes a 20 MHz system clock and word-aligned AHB-Lite register access.
*/
package evgt_pkg;

   // Widths
   localparam int unsigned CMD_W      = 16;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned NUM_LEVELS = 13;
   localparam int unsigned LVL_W      = 4;
   localparam int unsigned IDX_W      = 8;

   // Command word fields
   localparam int unsigned CMD_CODE_LSB = 8;
   localparam int unsigned CMD_DATA_LSB = 0;

   // Command codes, also the word index of their direct register
   localparam logic [7:0] CODE_LVL13       = 8'h30;
   localparam logic [7:0] CODE_LVL12       = 8'h31;
   localparam logic [7:0] CODE_LVL11       = 8'h32;
   localparam logic [7:0] CODE_LVL10       = 8'h33;
   localparam logic [7:0] CODE_LVL9        = 8'h34;
   localparam logic [7:0] CODE_LVL8        = 8'h35;
   localparam logic [7:0] CODE_LVL7        = 8'h36;
   localparam logic [7:0] CODE_LVL6        = 8'h37;
   localparam logic [7:0] CODE_LVL5        = 8'h38;
   localparam logic [7:0] CODE_LVL4        = 8'h39;
   localparam logic [7:0] CODE_LVL3        = 8'h3a;
   localparam logic [7:0] CODE_LVL2        = 8'h3b;
   localparam logic [7:0] CODE_LVL1        = 8'h3c;
   localparam logic [7:0] CODE_SLEEP       = 8'hf1;
   localparam logic [7:0] CODE_SOFT_REINIT = 8'hf2;

   // Extra registers (word index)
   localparam logic [7:0] IDX_CMD_WORD = 8'h00;
   localparam logic [7:0] IDX_CTRL     = 8'h01;
   localparam logic [7:0] IDX_STATUS   = 8'h02;

   // Field positions
   localparam int unsigned SLEEP_SEL_BIT   = 0;
   localparam int unsigned CTRL_RUN_BIT    = 0;
   localparam int unsigned CTRL_STEPUP_BIT = 1;
   localparam int unsigned ST_SLEEP_BIT    = 0;
   localparam int unsigned ST_BUSY_BIT     = 1;
   localparam int unsigned ST_RUN_BIT      = 2;
   localparam int unsigned ST_STEPUP_BIT   = 3;
   localparam int unsigned ST_LEVEL_LSB    = 8;
   localparam int unsigned ST_CODE_LSB     = 16;

   // Reset values
   localparam logic [7:0] RST_LVL13 = 8'h79;
   localparam logic [7:0] RST_LVL12 = 8'h53;
   localparam logic [7:0] RST_LVL11 = 8'h39;
   localparam logic [7:0] RST_LVL10 = 8'h27;
   localparam logic [7:0] RST_LVL9  = 8'h1a;
   localparam logic [7:0] RST_LVL8  = 8'h12;
   localparam logic [7:0] RST_LVL7  = 8'h0c;
   localparam logic [7:0] RST_LVL6  = 8'h08;
   localparam logic [7:0] RST_LVL5  = 8'h05;
   localparam logic [7:0] RST_LVL4  = 8'h03;
   localparam logic [7:0] RST_LVL3  = 8'h02;
   localparam logic [7:0] RST_LVL2  = 8'h01;
   localparam logic [7:0] RST_LVL1  = 8'h00;
   localparam logic [7:0] RST_SLEEP = 8'h00;

   // AHB encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned SOFT_REINIT_NS  = 200;
   localparam int unsigned SOFT_REINIT_CYC =
      (SOFT_REINIT_NS / CLK_PERIOD_NS) < 1 ? 1 : (SOFT_REINIT_NS / CLK_PERIOD_NS);
   localparam int unsigned GSTEP_HALF_DIV_DEF = 4;

   // Level addressed by a command code, zero when it is no table command
   function automatic logic [3:0] cmd_level(input logic [7:0] code);
      case (code)
         CODE_LVL13: cmd_level = 4'hd;
         CODE_LVL12: cmd_level = 4'hc;
         CODE_LVL11: cmd_level = 4'hb;
         CODE_LVL10: cmd_level = 4'ha;
         CODE_LVL9:  cmd_level = 4'h9;
         CODE_LVL8:  cmd_level = 4'h8;
         CODE_LVL7:  cmd_level = 4'h7;
         CODE_LVL6:  cmd_level = 4'h6;
         CODE_LVL5:  cmd_level = 4'h5;
         CODE_LVL4:  cmd_level = 4'h4;
         CODE_LVL3:  cmd_level = 4'h3;
         CODE_LVL2:  cmd_level = 4'h2;
         CODE_LVL1:  cmd_level = 4'h1;
         default:    cmd_level = 4'h0;
      endcase
   endfunction

   // Default length byte of a level
   function automatic logic [7:0] lvl_default(input logic [3:0] lvl);
      case (lvl)
         4'hd:    lvl_default = RST_LVL13;
         4'hc:    lvl_default = RST_LVL12;
         4'hb:    lvl_default = RST_LVL11;
         4'ha:    lvl_default = RST_LVL10;
         4'h9:    lvl_default = RST_LVL9;
         4'h8:    lvl_default = RST_LVL8;
         4'h7:    lvl_default = RST_LVL7;
         4'h6:    lvl_default = RST_LVL6;
         4'h5:    lvl_default = RST_LVL5;
         4'h4:    lvl_default = RST_LVL4;
         4'h3:    lvl_default = RST_LVL3;
         4'h2:    lvl_default = RST_LVL2;
         default: lvl_default = RST_LVL1;
      endcase
   endfunction

endpackage

// *** rtl/evgt_slot_timer.sv ***
/*
 Gray slot timer: measures one gray level as length byte plus one gray-step ticks.
 Assumes tick is a one-cycle enable on the system clock and len is stable in a slot.
*/
`timescale 1ns/1ps
`default_nettype none

module evgt_slot_timer #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         restart,
   input  wire logic         tick,
   input  wire logic [W-1:0] len,
   // Slot end
   output logic              done
);

   logic [W-1:0] cnt_q;

   // Last tick of the slot; a byte of zero gives a single tick
   assign done = tick & (cnt_q == len);

   // Tick counter, cleared whenever the sweep is idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (restart) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= done ? '0 : W'(cnt_q + 1'b1);
      end
   end

endmodule

`default_nettype wire

// *** bench/evgt_properties.sv ***
/*
 Checker of the even gray timing bank, bound to its top module.
 Assumes HREADY is the slave's own HREADYOUT and a single master.
*/
`timescale 1ns/1ps
`default_nettype none

module evgt_checker #(
   parameter int unsigned GSTEP_HALF_DIV = 4
) (
   // System
   input wire logic        CLK,
   input wire logic        RESET_N,
   // Bus
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic [2:0]  HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic        HREADY,
   input wire logic        HREADYOUT,
   input wire logic        HRESP,
   // Driver and power outputs
   input wire logic        SCLK_OUT,
   input wire logic        FRAME_SYNC_OUT,
   input wire logic        ROW_SYNC_OUT,
   input wire logic        ROW_CTRL_A_OUT,
   input wire logic        ROW_CTRL_B_OUT,
   input wire logic        ROW_SHIFT_BIT_OUT,
   input wire logic        OSC_RUN_OUT,
   input wire logic        STEPUP_EN_OUT,
   input wire logic        COL_DRV_LOW_OUT,
   input wire logic        ROW_DRV_LOW_OUT,
   input wire logic        SLEEP_OUT,
   input wire logic [3:0]  GRAY_LEVEL_OUT
);
   logic       sclk_q;
   logic       seen_q;
   logic [7:0] cnt_q;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   // Cycles since the gray clock moved; first move skipped, divider phase is free
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sclk_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q  <= 8'h00;
      end else begin
         sclk_q <= SCLK_OUT;
         if (SCLK_OUT != sclk_q) begin
            seen_q <= 1'b1;
            cnt_q  <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end

   // Word write address phase to one register index
   sequence s_addr(logic [7:0] idx);
      HSEL && HTRANS[1] && HREADY && HWRITE && HSIZE == evgt_pkg::HSIZE_WORD && HADDR[9:2] == idx;
   endsequence

   // A command, direct or through the command word, ending in its data phase
   sequence s_cmd(logic [7:0] c);
      (s_addr(c) ##1 1'b1) or (s_addr(8'h00) ##1 HWDATA[15:8] == c);
   endsequence

   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not zero-wait OKAY");
   a_osc_runs: assert property (OSC_RUN_OUT)
      else $error("oscillator stopped");
   a_idle_low: assert property (!ROW_CTRL_A_OUT |-> COL_DRV_LOW_OUT && ROW_DRV_LOW_OUT
      && !ROW_SYNC_OUT && !ROW_CTRL_B_OUT && GRAY_LEVEL_OUT == 4'h0)
      else $error("idle drivers not at rest");
   a_frame_marks: assert property ((FRAME_SYNC_OUT || ROW_SHIFT_BIT_OUT)
      |-> FRAME_SYNC_OUT && ROW_SHIFT_BIT_OUT && ROW_SYNC_OUT)
      else $error("frame marks out of step");
   a_row_pulse: assert property ($rose(ROW_SYNC_OUT) |=> !ROW_SYNC_OUT)
      else $error("row sync longer than one cycle");
   a_level_range: assert property (ROW_CTRL_A_OUT |-> GRAY_LEVEL_OUT inside {[4'h1:4'hd]}
      && ROW_CTRL_B_OUT == (GRAY_LEVEL_OUT == 4'h1))
      else $error("gray level out of range");
   a_sclk_half: assert property (seen_q |-> ((SCLK_OUT != sclk_q) == (cnt_q == GSTEP_HALF_DIV - 1)))
      else $error("gray clock half period wrong");
   a_sleep_enter: assert property (s_cmd(8'hf1) ##0 HWDATA[0] |=> ##[0:1] SLEEP_OUT)
      else $error("sleep select not taken");
   a_sleep_quiet: assert property (SLEEP_OUT [*2] |-> !ROW_CTRL_A_OUT && !STEPUP_EN_OUT)
      else $error("drivers busy while asleep");
   a_reinit_off: assert property (s_cmd(8'hf2) |-> ##4 (!SLEEP_OUT && !STEPUP_EN_OUT && !ROW_CTRL_A_OUT))
      else $error("reinit not done in time");
endmodule

bind evgt_even_gray_table evgt_checker #(
   .GSTEP_HALF_DIV(GSTEP_HALF_DIV)
) i_chk (
   .CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HREADYOUT,
   .HRESP, .SCLK_OUT, .FRAME_SYNC_OUT, .ROW_SYNC_OUT, .ROW_CTRL_A_OUT, .ROW_CTRL_B_OUT,
   .ROW_SHIFT_BIT_OUT, .OSC_RUN_OUT, .STEPUP_EN_OUT, .COL_DRV_LOW_OUT, .ROW_DRV_LOW_OUT,
   .SLEEP_OUT, .GRAY_LEVEL_OUT
);

`default_nettype wire

// *** bench/evgt_host_model.sv ***
/*
 Host model: AHB-Lite master issuing single word transfers.
 Assumes one slave whose HREADYOUT is the bus ready; caller enters at a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module evgt_host_model (
   // Bus clock
   input  wire logic        clk,
   // Master outputs
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata,
   // Slave answer
   input  wire logic [31:0] hrdata,
   input  wire logic        hready
);
   // Idle bus from time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h0;
      hwdata = 32'h0;
   end

   // One word transfer after gap idle cycles; returns read data and ok, cleared on timeout
   task automatic xfer(input logic w, input logic [31:0] a, d, input logic [1:0] gap,
                       output logic [31:0] r, output logic ok);
      int n;
      repeat (gap) @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      hsize  <= evgt_pkg::HSIZE_WORD;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      if (w)
         hwdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 128);
      r  = hrdata;
      ok = (n < 128);
      // Released data lines show the inverse
      if (w)
         hwdata <= ~d;
   endtask
endmodule

`default_nettype wire

// *** bench/tb.sv ***
/*
 Self-checking bench for the even gray timing bank.
 Assumes the host model drives the bus and the checker is bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int unsigned DIV = 2;
   logic        CLK, RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, SCLK_OUT, FRAME_SYNC_OUT;
   logic        ROW_SYNC_OUT, ROW_CTRL_A_OUT, ROW_CTRL_B_OUT, ROW_SHIFT_BIT_OUT, OSC_RUN_OUT;
   logic        STEPUP_EN_OUT, COL_DRV_LOW_OUT, ROW_DRV_LOW_OUT, SLEEP_OUT;
   logic [31:0] HADDR, HWDATA, HRDATA, seed;
   logic [1:0]  HTRANS;
   logic [2:0]  HSIZE;
   logic [3:0]  GRAY_LEVEL_OUT;
   logic [7:0]  tbl [1:13];
   logic [7:0]  dflt [1:13];
   logic [7:0]  sv [0:2];
   int          fail_count, checks;

   evgt_even_gray_table #(.GSTEP_HALF_DIV(DIV)) i_evgt_even_gray_table (
      .CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT),
      .HRDATA, .HREADYOUT, .HRESP, .SCLK_OUT, .FRAME_SYNC_OUT, .ROW_SYNC_OUT, .ROW_CTRL_A_OUT,
      .ROW_CTRL_B_OUT, .ROW_SHIFT_BIT_OUT, .OSC_RUN_OUT, .STEPUP_EN_OUT, .COL_DRV_LOW_OUT,
      .ROW_DRV_LOW_OUT, .SLEEP_OUT, .GRAY_LEVEL_OUT);
   evgt_host_model i_host (.clk(CLK), .hsel(HSEL), .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE),
      .hsize(HSIZE), .hwdata(HWDATA), .hrdata(HRDATA), .hready(HREADYOUT));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v  = s ^ (s << 13);
      v  = v ^ (v >> 17);
      xs = v ^ (v << 5);
   endfunction

   // Slot length in system cycles: byte plus one gray-step periods
   function automatic logic [15:0] slot_len(input logic [7:0] e);
      slot_len = ({8'h0, e} + 16'h1) * 16'(2 * DIV);
   endfunction

   task automatic report_and_stop();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Random idle gap before each transfer
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      logic ok;
      seed = xs(seed);
      i_host.xfer(w, a, d, seed[1:0], r, ok);
      if (!ok) begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [31:0] a, e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      cmp_reg(r, e);
   endtask

   task automatic cmd(input logic [7:0] c, d);
      wr(32'h0, {16'h0, c, d});
   endtask

   // Align on a frame end, then time each row sync gap for levels 1 to 13
   task automatic check_frame();
      int          n;
      logic [15:0] len;
      n = 0;
      while (FRAME_SYNC_OUT !== 1'b1 && n < 9000) begin
         @(negedge CLK);
         n++;
      end
      cmp_reg({31'h0, FRAME_SYNC_OUT}, 32'h1);
      for (int k = 1; k <= 13; k++) begin
         len = 16'h0;
         do begin
            @(negedge CLK);
            len++;
         end while (ROW_SYNC_OUT !== 1'b1 && len < 16'h1000);
         cmp_reg({16'h0, len}, {16'h0, slot_len(tbl[k])});
         if (len >= 16'h1000 || n >= 9000)
            report_and_stop();
      end
      cmp_reg({31'h0, FRAME_SYNC_OUT}, 32'h1);
      @(posedge CLK);
   endtask

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   initial begin
      fail_count = 0;
      checks     = 0;
      seed       = 32'h6a65;
      RESET_N    = 1'b0;
      dflt = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h12, 8'h1a, 8'h27, 8'h39, 8'h53, 8'h79};
      sv   = '{8'hff, 8'hfe, 8'h01};
      tbl  = dflt;
      repeat (16) @(posedge CLK);
      RESET_N <= 1'b1;
      @(negedge CLK);
      cmp_reg({28'h0, OSC_RUN_OUT, COL_DRV_LOW_OUT, ROW_DRV_LOW_OUT, SLEEP_OUT}, 32'he);
      @(posedge CLK);
      rd_chk(32'h004, 32'h0);
      rd_chk(32'h0c4, 32'h0); // write-only entry reads zero
      rd_chk(32'h3fc, 32'h0); // unmapped
      wr(32'h004, 32'h1);
      check_frame();
      // Level 1 at its longest, level 13 at its shortest, others random
      wr(32'h004, 32'h0);
      for (int k = 1; k <= 13; k++) begin
         seed   = xs(seed);
         tbl[k] = (k == 1) ? 8'hff : (k == 13) ? 8'h00 : {3'h0, seed[4:0]};
         if (seed[8])
            cmd(8'h3d - 8'(k), tbl[k]);
         else
            wr({22'h0, 8'h3d - 8'(k), 2'h0}, {seed[31:8], tbl[k]});
      end
      wr(32'h004, 32'h3);
      rd_chk(32'h004, 32'h3);
      check_frame();
      // Upper data bits must not disturb the select
      for (int k = 0; k < 3; k++) begin
         if (k == 1)
            cmd(8'hf1, sv[k]);
         else
            wr(32'h3c4, {24'h0, sv[k]});
         repeat (3) @(negedge CLK);
         cmp_reg({29'h0, SLEEP_OUT, ROW_CTRL_A_OUT, STEPUP_EN_OUT}, {29'h0, sv[k][0], {2{~sv[k][0]}}});
         @(posedge CLK);
      end
      seed = xs(seed);
      cmd(8'hf2, seed[7:0]);
      repeat (4) @(negedge CLK);
      cmp_reg({22'h0, OSC_RUN_OUT, STEPUP_EN_OUT, COL_DRV_LOW_OUT, ROW_DRV_LOW_OUT, FRAME_SYNC_OUT,
               ROW_SYNC_OUT, ROW_CTRL_A_OUT, ROW_CTRL_B_OUT, ROW_SHIFT_BIT_OUT, SLEEP_OUT}, 32'h2c0);
      @(posedge CLK);
      rd_chk(32'h008, 32'h00f20000);
      rd_chk(32'h004, 32'h0);
      repeat (4) @(posedge CLK);
      wr(32'h004, 32'h1);
      tbl = dflt;
      check_frame();
      report_and_stop();
   end
endmodule

`default_nettype wire
